/* hdl/alm_lane_mapper.sv */
// Transport framing of converter samples onto up to eight serial lanes
//
// Contract
// - Mode 0: eight octets per lane, five 12-bit fields then a zero nibble.
// - Mode 0: lane pairs carry even and odd samples of channels A to D.
// - Mode 1: two octets per lane, 12-bit fields run across lane boundaries.
// - Mode 1: lane 2 dual/quad, lanes 3-5 quad; missing channel B octet zero.
// - Mode 2: one 8-bit sample per lane, lanes 0-3 carry channels A-D.
// - Mode 3: five octets per lane, four 10-bit fields of one channel.
// - Samples go out MSB first and every tail bit is zero.
// - Lowest lanes are used, the rest powered down; receiver uses lowest lanes.
`timescale 1ns/100ps
module alm_lane_mapper import alm_pkg::*; (
	input  wire logic        clk_in,               // 100 MHz clock
	input  wire logic        reset_in,             // Synchronous reset, active high
	input  wire logic [1:0]  link_mode_select_in,  // Link mode pins 0..3
	input  wire logic [1:0]  variant_in,           // 0 single, 1 dual, 2 quad
	input  wire logic        sample_valid_in,      // One sample per channel this cycle
	input  wire logic [8:0]  sample_a_in,          // Channel A sample
	input  wire logic [8:0]  sample_b_in,          // Channel B sample
	input  wire logic [8:0]  sample_c_in,          // Channel C sample
	input  wire logic [8:0]  sample_d_in,          // Channel D sample
	output logic      [63:0] serial_lane_0_out,    // Lane 0 frame, octet 0 in top bits
	output logic      [63:0] serial_lane_1_out,    // Lane 1 frame
	output logic      [63:0] serial_lane_2_out,    // Lane 2 frame
	output logic      [63:0] serial_lane_3_out,    // Lane 3 frame
	output logic      [63:0] serial_lane_4_out,    // Lane 4 frame
	output logic      [63:0] serial_lane_5_out,    // Lane 5 frame
	output logic      [63:0] serial_lane_6_out,    // Lane 6 frame
	output logic      [63:0] serial_lane_7_out,    // Lane 7 frame
	output logic      [7:0]  lane_active_out,      // High per lane in use, low is powered down
	output logic             frame_valid_out       // One-cycle pulse, new frame on lanes
);
	////////////////////////////////////////////////////////////////////////
	logic [1:0]  mode_meta_r, mode_sync_r, var_meta_r, var_sync_r;
	logic [1:0]  mode_r, var_r, asm_mode_r, asm_var_r;
	logic [3:0]  cnt_r;
	logic        frame_go_r, frame_valid_r;
	logic [7:0]  lane_active_r;
	logic [8:0]  smp_r [ALM_CHANS][ALM_DEPTH];
	logic [63:0] lane_r [ALM_LANES];
	logic [63:0] lane_nxt [ALM_LANES];
	wire  [8:0]  smp_in [ALM_CHANS];
	wire  [3:0]  need_w      = alm_frame_len(mode_r);
	wire         last_w      = sample_valid_in && (cnt_r == 4'(need_w - 4'h1));
	wire         load_mode_w = last_w || (cnt_r == ALM_CNT_RST && !sample_valid_in);
	wire  [3:0]  asm_lanes_w = alm_lane_cnt(asm_mode_r, asm_var_r);
	wire  [3:0]  cur_lanes_w = alm_lane_cnt(mode_r, var_r);

	assign smp_in[0] = sample_a_in;
	assign smp_in[1] = sample_b_in;
	assign smp_in[2] = sample_c_in;
	assign smp_in[3] = sample_d_in;

	////////////////////////////////////////////////////////////////////////
	// Pins are asynchronous to the frame logic
	always_ff @(posedge clk_in) begin
		mode_meta_r <= link_mode_select_in;
		mode_sync_r <= mode_meta_r;
		var_meta_r  <= variant_in;
		var_sync_r  <= var_meta_r;
	end

	// Mode changes only between frames so a frame never mixes layouts
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cnt_r      <= ALM_CNT_RST;
			mode_r     <= ALM_MODE_RST;
			var_r      <= ALM_VAR_RST;
			asm_mode_r <= ALM_MODE_RST;
			asm_var_r  <= ALM_VAR_RST;
			frame_go_r <= 1'b0;
		end else begin
			cnt_r      <= last_w ? ALM_CNT_RST : (sample_valid_in ? 4'(cnt_r + 4'h1) : cnt_r);
			frame_go_r <= last_w;
			if (last_w) begin
				asm_mode_r <= mode_r;
				asm_var_r  <= var_r;
			end
			if (load_mode_w) begin
				mode_r <= mode_sync_r;
				var_r  <= var_sync_r;
			end
		end
	end

	// Sample store; slot 0 may be rewritten while the frame is read, old value wins
	always_ff @(posedge clk_in) begin
		for (int c = 0; c < ALM_CHANS; c++) begin
			if (sample_valid_in)
				smp_r[c][cnt_r] <= smp_in[c];
		end
	end

	////////////////////////////////////////////////////////////////////////
	for (genvar l = 0; l < ALM_LANES; l++) begin : g_lane
		localparam int CH = l / 2;
		localparam int PR = l % 2;
		// Lanes 6 and 7 never carry mode 1 data; group held in range so channel indices stay legal
		localparam int GR = (l < 6) ? l / 3 : 0;
		localparam int PT = l % 3;
		wire [63:0] m0_w = {alm_f12(smp_r[CH][PR]), alm_f12(smp_r[CH][PR + 2]), alm_f12(smp_r[CH][PR + 4]),
			alm_f12(smp_r[CH][PR + 6]), alm_f12(smp_r[CH][PR + 8]), 4'h0};
		// Unused variant code counts as single, so anything but dual or quad has no channel B
		wire        no_b_w = (asm_var_r != ALM_VAR_DUAL) && (asm_var_r != ALM_VAR_QUAD);
		wire [23:0] y_w    = no_b_w ? 24'h0 : {alm_f12(smp_r[2 * GR + 1][0]), alm_f12(smp_r[2 * GR + 1][1])};
		wire [47:0] seg_w  = {alm_f12(smp_r[2 * GR][0]), alm_f12(smp_r[2 * GR][1]), y_w};
		wire [63:0] m1_w   = (l < 6) ? {seg_w[47 - 16 * PT -: 16], 48'h0} : 64'h0;
		wire [63:0] m2_w;
		wire [63:0] m3_w;
		if (l < 4) begin : g_low
			assign m2_w = {smp_r[l][0][8:1], 56'h0};
			assign m3_w = {alm_f10(smp_r[l][0]), alm_f10(smp_r[l][1]), alm_f10(smp_r[l][2]),
				alm_f10(smp_r[l][3]), 24'h0};
		end else begin : g_high
			assign m2_w = 64'h0;
			assign m3_w = 64'h0;
		end
		wire        on_w  = (4'(l) < asm_lanes_w);
		wire [63:0] sel_w = (asm_mode_r == ALM_MODE_0) ? m0_w :
			(asm_mode_r == ALM_MODE_1) ? m1_w :
			(asm_mode_r == ALM_MODE_2) ? m2_w : m3_w;
		assign lane_nxt[l] = on_w ? sel_w : 64'h0;

		always_ff @(posedge clk_in) begin
			if (reset_in) begin
				lane_r[l]        <= 64'h0;
				lane_active_r[l] <= 1'b0;
			end else begin
				lane_active_r[l] <= (4'(l) < cur_lanes_w);
				if (frame_go_r)
					lane_r[l] <= lane_nxt[l];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in)
			frame_valid_r <= 1'b0;
		else
			frame_valid_r <= frame_go_r;
	end

	assign serial_lane_0_out = lane_r[0];
	assign serial_lane_1_out = lane_r[1];
	assign serial_lane_2_out = lane_r[2];
	assign serial_lane_3_out = lane_r[3];
	assign serial_lane_4_out = lane_r[4];
	assign serial_lane_5_out = lane_r[5];
	assign serial_lane_6_out = lane_r[6];
	assign serial_lane_7_out = lane_r[7];
	assign lane_active_out   = lane_active_r;
	assign frame_valid_out   = frame_valid_r;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	frame_after_last_a: assert property (last_w |-> ##2 frame_valid_out)
		else $error("frame pulse not two cycles after last sample");
	frame_pulse_one_a: assert property (frame_valid_out |=> !frame_valid_out)
		else $error("frame pulse longer than one cycle");
	mode0_tail_a: assert property (frame_valid_out && asm_mode_r == ALM_MODE_0 |-> lane_r[0][3:0] == 4'h0)
		else $error("mode 0 tail nibble not zero");
	// Slot 0 may already hold the next frame's first sample, so compare with the previous cycle's store
	mode0_first_a: assert property (frame_valid_out && asm_mode_r == ALM_MODE_0 |->
		lane_r[0][63:55] == $past(smp_r[0][0]) && lane_r[1][63:55] == $past(smp_r[0][1]))
		else $error("mode 0 lane pair does not start with samples 0 and 1");
	mode1_no_b_a: assert property (frame_valid_out && asm_mode_r == ALM_MODE_1 && asm_var_r == ALM_VAR_SINGLE |->
		lane_r[1][55:48] == 8'h0 && lane_r[2] == 64'h0)
		else $error("mode 1 single variant channel B octet not zero");
	mode1_span_a: assert property (frame_valid_out && asm_mode_r == ALM_MODE_1 |->
		lane_r[0][51:48] == smp_r[0][1][8:5] && lane_r[1][63:59] == smp_r[0][1][4:0])
		else $error("mode 1 sample not split across lanes 0 and 1");
	mode2_octet_a: assert property (frame_valid_out && asm_mode_r == ALM_MODE_2 |->
		lane_r[0][55:0] == 56'h0 && lane_r[4] == 64'h0 && lane_r[5] == 64'h0 &&
		lane_r[6] == 64'h0 && lane_r[7] == 64'h0)
		else $error("mode 2 lane holds more than one octet");
	mode3_pad_a: assert property (frame_valid_out && asm_mode_r == ALM_MODE_3 |->
		lane_r[0][54] == 1'b0 && lane_r[0][23:0] == 24'h0)
		else $error("mode 3 padding bit not zero");
	// Active flags lag the adopted mode by one cycle; the cycle before the pulse shows this frame's lanes
	lane_off_a: assert property (frame_valid_out && !$past(lane_active_out[7]) |->
		serial_lane_7_out == 64'h0)
		else $error("powered down lane carries data");

	mode0_frame_c: cover property (frame_valid_out && asm_mode_r == ALM_MODE_0 && asm_var_r == ALM_VAR_QUAD);
	mode1_dual_c:  cover property (frame_valid_out && asm_mode_r == ALM_MODE_1 && asm_var_r == ALM_VAR_DUAL);
	mode2_frame_c: cover property (frame_valid_out && asm_mode_r == ALM_MODE_2);
	mode3_frame_c: cover property (frame_valid_out && asm_mode_r == ALM_MODE_3 ##[1:40] frame_valid_out);
endmodule // alm_lane_mapper

/* hdl/alm_pkg.sv */
// Constants and decode helpers for the lane mapper
package alm_pkg;
	localparam int          ALM_SMP_W     = 9;
	localparam int          ALM_LANES     = 8;
	localparam int          ALM_CHANS     = 4;
	localparam int          ALM_DEPTH     = 10;
	localparam int          ALM_WORD_W    = 64;
	// Link mode codes
	localparam logic [1:0]  ALM_MODE_0    = 2'h0;
	localparam logic [1:0]  ALM_MODE_1    = 2'h1;
	localparam logic [1:0]  ALM_MODE_2    = 2'h2;
	localparam logic [1:0]  ALM_MODE_3    = 2'h3;
	// Device variant codes
	localparam logic [1:0]  ALM_VAR_SINGLE = 2'h0;
	localparam logic [1:0]  ALM_VAR_DUAL   = 2'h1;
	localparam logic [1:0]  ALM_VAR_QUAD   = 2'h2;
	// Samples per channel per frame
	localparam logic [3:0]  ALM_LEN_0     = 4'ha;
	localparam logic [3:0]  ALM_LEN_1     = 4'h2;
	localparam logic [3:0]  ALM_LEN_2     = 4'h1;
	localparam logic [3:0]  ALM_LEN_3     = 4'h4;
	// Reset values
	localparam logic [3:0]  ALM_CNT_RST   = 4'h0;
	localparam logic [1:0]  ALM_MODE_RST  = 2'h0;
	localparam logic [1:0]  ALM_VAR_RST   = 2'h2;

	function automatic logic [3:0] alm_frame_len(input logic [1:0] mode);
		case (mode)
			ALM_MODE_0: alm_frame_len = ALM_LEN_0;
			ALM_MODE_1: alm_frame_len = ALM_LEN_1;
			ALM_MODE_2: alm_frame_len = ALM_LEN_2;
			default:    alm_frame_len = ALM_LEN_3;
		endcase
	endfunction

	// Number of lowest lanes in use for a mode and variant
	function automatic logic [3:0] alm_lane_cnt(input logic [1:0] mode, input logic [1:0] vari);
		logic [3:0] base;
		base = 4'h0;
		case (mode)
			ALM_MODE_0: base = 4'h2;
			ALM_MODE_1: base = 4'h2;
			default:    base = 4'h1;
		endcase
		case (vari)
			ALM_VAR_QUAD: alm_lane_cnt = (mode == ALM_MODE_1) ? 4'h6 : 4'(base << 2);
			ALM_VAR_DUAL: alm_lane_cnt = (mode == ALM_MODE_1) ? 4'h3 : 4'(base << 1);
			default:      alm_lane_cnt = base;
		endcase
	endfunction

	function automatic logic [11:0] alm_f12(input logic [8:0] s);
		alm_f12 = {s, 3'h0};
	endfunction

	function automatic logic [9:0] alm_f10(input logic [8:0] s);
		alm_f10 = {s, 1'h0};
	endfunction
endpackage

/* dv/alm_rx_model.sv */
// Receiver-side model that recovers samples from the lowest lane
`timescale 1ns/100ps
module alm_rx_model (
	input  wire logic [63:0]     lane_in,  // Lowest lane frame
	output logic      [3:0][8:0] smp_out   // Recovered 10-bit-field samples
);
	// Padding bit dropped; only the upper nine bits carry the sample
	for (genvar i = 0; i < 4; i++) begin : g_fld
		assign smp_out[i] = lane_in[63-10*i -: 9];
	end
endmodule // alm_rx_model

/* dv/testbench.sv */
// Self-checking bench for the lane mapper
`timescale 1ns/100ps
module testbench import alm_pkg::*; ();
	logic             clk_in = 1'b0;
	logic             reset_in = 1'b1;
	logic [1:0]       mode = 2'h0;
	logic [1:0]       vari = 2'h2;
	logic             valid = 1'b0;
	logic [3:0][8:0]  smp_in = '0;
	logic [63:0]      ln [8];
	logic [7:0]       act;
	logic             frame_valid_out;
	logic [3:0][8:0]  rx_smp;
	int               n_mismatch = 0;
	int               checks_done = 0;
	int               cyc = 0;

	always #5 clk_in = ~clk_in;

	alm_lane_mapper u_dut (.clk_in(clk_in), .reset_in(reset_in), .link_mode_select_in(mode),
		.variant_in(vari), .sample_valid_in(valid), .sample_a_in(smp_in[0]), .sample_b_in(smp_in[1]),
		.sample_c_in(smp_in[2]), .sample_d_in(smp_in[3]), .serial_lane_0_out(ln[0]),
		.serial_lane_1_out(ln[1]), .serial_lane_2_out(ln[2]), .serial_lane_3_out(ln[3]),
		.serial_lane_4_out(ln[4]), .serial_lane_5_out(ln[5]), .serial_lane_6_out(ln[6]),
		.serial_lane_7_out(ln[7]), .lane_active_out(act), .frame_valid_out(frame_valid_out));
	// Receiver wired to the lowest lane only
	alm_rx_model u_rx (.lane_in(ln[0]), .smp_out(rx_smp));

	function automatic logic [8:0] smp(input int ch, input int k);
		smp = {2'(ch), 4'(k), 3'h5};
	endfunction

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s", $time, what);
		end
	endtask

	// Pins settle while idle, then n samples per channel back to back
	task automatic feed(input logic [1:0] m, input logic [1:0] v, input int n);
		@(negedge clk_in);
		mode = m;
		vari = v;
		repeat (4) @(negedge clk_in);
		for (int k = 0; k < n; k++) begin
			valid = 1'b1;
			for (int c = 0; c < 4; c++) smp_in[c] = smp(c, k);
			@(negedge clk_in);
		end
		valid = 1'b0;
		for (int i = 0; i < 8 && frame_valid_out !== 1'b1; i++) @(posedge clk_in) #1;
		chk(64'(frame_valid_out), 64'h1, "no frame");
	endtask

	task automatic t_mode0();
		logic [63:0] e;
		for (int v = 0; v < 3; v++) begin
			feed(ALM_MODE_0, 2'(v), 10);
			for (int l = 0; l < 8; l++) begin
				e = 64'h0;
				for (int j = 0; j < 5; j++) if (l < (2 << v)) e[63-12*j -: 12] = {smp(l/2, l%2+2*j), 3'h0};
				chk(ln[l], e, "mode0 lane");
			end
			chk(64'(act), 64'((1 << (2 << v)) - 1), "mode0 active");
		end
	endtask

	task automatic t_mode1();
		logic [47:0] g;
		logic [63:0] e;
		int          cnt;
		// Variant code 3 is run too and must behave as single
		for (int v = 0; v < 4; v++) begin
			feed(ALM_MODE_1, 2'(v), 2);
			cnt = (v == 2) ? 6 : (v == 1) ? 3 : 2;
			for (int l = 0; l < 8; l++) begin
				g = {smp(2*(l/3), 0), 3'h0, smp(2*(l/3), 1), 3'h0, 24'h0};
				if (v == 1 || v == 2) g[23:0] = {smp(2*(l/3)+1, 0), 3'h0, smp(2*(l/3)+1, 1), 3'h0};
				e = (l < cnt) ? {g[47-16*(l%3) -: 16], 48'h0} : 64'h0;
				chk(ln[l], e, "mode1 lane");
			end
			chk(64'(act), 64'((1 << cnt) - 1), "mode1 active");
		end
	endtask

	task automatic t_mode2();
		logic [8:0]  s;
		logic [63:0] e;
		for (int v = 0; v < 3; v++) begin
			feed(ALM_MODE_2, 2'(v), 1);
			for (int l = 0; l < 8; l++) begin
				s = smp(l, 0);
				e = (l < (1 << v)) ? {s[8:1], 56'h0} : 64'h0;
				chk(ln[l], e, "mode2 lane");
			end
			chk(64'(act), 64'((1 << (1 << v)) - 1), "mode2 active");
		end
	endtask

	task automatic t_mode3();
		logic [63:0] e;
		for (int v = 0; v < 3; v++) begin
			feed(ALM_MODE_3, 2'(v), 4);
			for (int l = 0; l < 8; l++) begin
				e = 64'h0;
				for (int j = 0; j < 4; j++) if (l < (1 << v)) e[63-10*j -: 10] = {smp(l, j), 1'h0};
				chk(ln[l], e, "mode3 lane");
			end
			for (int j = 0; j < 4; j++) chk(64'(rx_smp[j]), 64'(smp(0, j)), "rx sample");
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Whole run needs about 120 cycles
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			end_sim();
		end
	end

	initial begin
		repeat (2) @(negedge clk_in);
		chk(ln[0], 64'h0, "reset lane");
		reset_in = 1'b0;
		t_mode0();
		t_mode1();
		t_mode2();
		t_mode3();
		end_sim();
	end
endmodule // testbench
